// File: rtl/dui_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dui_ctrl (
  // Clock and reset
  input  wire logic                  REF_CLK_IN,
  input  wire logic                  RESET_IN,
  // AHB-Lite slave
  input  wire logic                  HSEL_IN,
  input  wire logic [31:0]           HADDR_IN,
  input  wire logic [1:0]            HTRANS_IN,
  input  wire logic                  HWRITE_IN,
  input  wire logic [2:0]            HSIZE_IN,
  input  wire logic [31:0]           HWDATA_IN,
  input  wire logic                  HREADY_IN,
  output logic      [31:0]           HRDATA_OUT,
  output logic                       HREADYOUT_OUT,
  output logic                       HRESP_OUT,
  // Event sources on this clock
  input  wire logic [7:0]            HOST_EVENTS_IN,
  input  wire dui_pkg::dui_dec_ev_t  DEC_EVENTS_IN,
  input  wire dui_pkg::dui_xfer_ev_t XFER_EVENTS_IN,
  input  wire dui_pkg::dui_ser_ev_t  SER_EVENTS_IN,
  // Asynchronous sync pins
  input  wire logic                  COMSYNC_IN,
  input  wire logic                  SYSSYNC_IN,
  // Requests to the sub-CPU
  output logic                       HOST_REQ_N_OUT,
  output logic                       DRIVE_REQ_N_OUT
);
  import dui_pkg::*;

  logic        acc;
  logic        map_ok;
  logic        dp_valid_r;
  logic        dp_write_r;
  logic        dp_ok_r;
  logic [15:0] dp_idx_r;
  logic        wr_go;
  logic        wr_ser_clr;
  logic        wr_ser_mask;
  logic        wr_dec_clr;
  logic        wr_dec_mask;
  logic        wr_xfer_clr;
  logic        wr_xfer_mask;
  logic [7:0]  wdata;
  logic [31:0] hrdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] a_idx;
  logic        host_req_n_r;
  logic        drive_req_n_r;
  logic        com_rise;
  logic        com_fall;
  logic        sys_rise;
  logic        sys_fall;
  logic [7:0]  dec_set;
  logic [7:0]  xfer_set;
  logic [7:0]  ser_set;
  logic [7:0]  dec_status;
  logic [7:0]  dec_mask;
  logic [7:0]  dec_shown;
  logic [7:0]  dec_view;
  logic [7:0]  xfer_status;
  logic [7:0]  xfer_mask;
  logic [7:0]  xfer_shown;
  logic [7:0]  xfer_view;
  logic [7:0]  ser_status;
  logic [7:0]  ser_mask;
  logic [7:0]  ser_shown;
  logic        dec_pend;
  logic        xfer_pend;
  logic        ser_pend;

  // Address phase decode; only aligned words in the map are live
  assign a_idx  = HADDR_IN[IDX_MSB:IDX_LSB];
  assign acc    = HSEL_IN & (HTRANS_IN == HTRANS_NONSEQ) & HREADY_IN;
  assign map_ok = (HADDR_IN[31:IDX_MSB+1] == ADDR_HI_ZERO) &
                  (HADDR_IN[IDX_LSB-1:0] == ADDR_LO_ZERO);

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_ok_r    <= 1'b0;
      dp_idx_r   <= 16'h0000;
    end else begin
      dp_valid_r <= acc;
      dp_write_r <= acc & HWRITE_IN;
      dp_ok_r    <= acc & map_ok;
      dp_idx_r   <= a_idx;
    end
  end

  // Write strobes in the data phase; unmapped writes vanish
  assign wr_go        = dp_valid_r & dp_write_r & dp_ok_r;
  assign wdata        = HWDATA_IN[7:0];
  assign wr_ser_clr   = wr_go & (dp_idx_r == IDX_SER_EVENT);
  assign wr_ser_mask  = wr_go & (dp_idx_r == IDX_SER_MASK);
  assign wr_dec_clr   = wr_go & (dp_idx_r == IDX_DEC_EVENT);
  assign wr_dec_mask  = wr_go & (dp_idx_r == IDX_DEC_MASK);
  assign wr_xfer_clr  = wr_go & (dp_idx_r == IDX_XFER_EVENT);
  assign wr_xfer_mask = wr_go & (dp_idx_r == IDX_XFER_MASK);

  // Sync pins pass two flops before edge detection
  dui_pin_edge u_com_edge (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RESET_IN),
    .pin_in   (COMSYNC_IN),
    .rise_out (com_rise),
    .fall_out (com_fall)
  );

  dui_pin_edge u_sys_edge (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RESET_IN),
    .pin_in   (SYSSYNC_IN),
    .rise_out (sys_rise),
    .fall_out (sys_fall)
  );

  // Event to bit mapping; summary positions never latch
  assign dec_set = {DEC_EVENTS_IN, 1'b0};
  assign xfer_set = {XFER_EVENTS_IN.host_count_zero,
                     XFER_EVENTS_IN.drive_reload,
                     XFER_EVENTS_IN.host_reloads_exhausted_flag,
                     XFER_EVENTS_IN.copy_done,
                     XFER_EVENTS_IN.subcode_early_sync,
                     XFER_EVENTS_IN.dma_count_zero & XFER_EVENTS_IN.dma_active,
                     2'b00};
  assign ser_set = {com_rise, sys_rise, com_fall, sys_fall,
                    SER_EVENTS_IN.tx_empty,
                    SER_EVENTS_IN.rx_full,
                    SER_EVENTS_IN.rx_overrun,
                    SER_EVENTS_IN.rx_parity_bad};

  dui_event_group #(.CLR_BITS(DEC_CLR_BITS)) u_dec_group (
    .clk_in      (REF_CLK_IN),
    .rst_in      (RESET_IN),
    .set_in      (dec_set),
    .clr_wr_in   (wr_dec_clr),
    .mask_wr_in  (wr_dec_mask),
    .wdata_in    (wdata),
    .status_out  (dec_status),
    .mask_out    (dec_mask),
    .shown_out   (dec_shown),
    .pending_out (dec_pend)
  );

  dui_event_group #(.CLR_BITS(XFER_CLR_BITS)) u_xfer_group (
    .clk_in      (REF_CLK_IN),
    .rst_in      (RESET_IN),
    .set_in      (xfer_set),
    .clr_wr_in   (wr_xfer_clr),
    .mask_wr_in  (wr_xfer_mask),
    .wdata_in    (wdata),
    .status_out  (xfer_status),
    .mask_out    (xfer_mask),
    .shown_out   (xfer_shown),
    .pending_out (xfer_pend)
  );

  dui_event_group #(.CLR_BITS(SER_CLR_BITS)) u_ser_group (
    .clk_in      (REF_CLK_IN),
    .rst_in      (RESET_IN),
    .set_in      (ser_set),
    .clr_wr_in   (wr_ser_clr),
    .mask_wr_in  (wr_ser_mask),
    .wdata_in    (wdata),
    .status_out  (ser_status),
    .mask_out    (ser_mask),
    .shown_out   (ser_shown),
    .pending_out (ser_pend)
  );

  // Cross summaries; decoder bit zero still needs its enable
  always_comb begin
    dec_view               = dec_shown;
    dec_view[DEC_XFER_BIT] = xfer_pend & dec_mask[DEC_XFER_BIT];
    xfer_view               = xfer_shown & XFER_CLR_BITS;
    xfer_view[XFER_DEC_BIT] = dec_pend;
    xfer_view[XFER_SER_BIT] = ser_pend;
  end

  // Registered pins avoid glitches toward the sub-CPU
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      host_req_n_r <= 1'b1;
    end else begin
      host_req_n_r <= ~(|HOST_EVENTS_IN);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      drive_req_n_r <= 1'b1;
    end else begin
      drive_req_n_r <= ~(dec_pend | xfer_pend | ser_pend);
    end
  end

  // Read mux; masks are write-only and read as zero
  always_comb begin
    rdata_nxt = RDATA_ZERO;
    if (map_ok) begin
      unique case (a_idx)
        IDX_SER_EVENT:  rdata_nxt[7:0] = ser_shown;
        IDX_DEC_EVENT:  rdata_nxt[7:0] = dec_view;
        IDX_XFER_EVENT: rdata_nxt[7:0] = xfer_view;
        IDX_HOST_EVENT: rdata_nxt[7:0] = HOST_EVENTS_IN;
        default:        rdata_nxt      = RDATA_ZERO;
      endcase
    end
  end

  // Read data snapshot at the address phase
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      hrdata_r <= RDATA_ZERO;
    end else if (acc & ~HWRITE_IN) begin
      hrdata_r <= rdata_nxt;
    end
  end

  assign HRDATA_OUT      = hrdata_r;
  assign HREADYOUT_OUT   = 1'b1;
  assign HRESP_OUT       = HRESP_OKAY;
  assign HOST_REQ_N_OUT  = host_req_n_r;
  assign DRIVE_REQ_N_OUT = drive_req_n_r;

  // Checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  host_req_a : assert property (
    (|HOST_EVENTS_IN) |=> !HOST_REQ_N_OUT
  ) else $error("host request not asserted for host event");

  host_idle_a : assert property (
    (HOST_EVENTS_IN == 8'h00) |=> HOST_REQ_N_OUT
  ) else $error("host request active without host event");

  dec_clear_a : assert property (
    wr_dec_clr && wdata[7] && !DEC_EVENTS_IN.block_decoded |=> !dec_status[7]
  ) else $error("decoder bit 7 not cleared by write one");

  dec_sticky_a : assert property (
    dec_status[6] && !(wr_dec_clr && wdata[6]) |=> dec_status[6]
  ) else $error("decoder bit 6 lost without clear");

  mask_hides_a : assert property (
    (dec_mask == 8'h00 && xfer_mask == 8'h00 && ser_mask == 8'h00) [*2] |=> DRIVE_REQ_N_OUT
  ) else $error("drive request with every enable off");

  drive_req_a : assert property (
    (dec_pend || xfer_pend || ser_pend) |=> !DRIVE_REQ_N_OUT
  ) else $error("drive request missing for pending event");

  dma_event_a : assert property (
    XFER_EVENTS_IN.dma_count_zero && !XFER_EVENTS_IN.dma_active && !xfer_status[2] |=> !xfer_status[2]
  ) else $error("transfer bit 2 set without active transfer");

  dec_summary_a : assert property (
    (|(xfer_status & xfer_mask & XFER_CLR_BITS)) && dec_mask[DEC_XFER_BIT] |-> dec_view[DEC_XFER_BIT]
  ) else $error("decoder summary misses transfer event");

  com_rise_a : assert property (
    $rose(COMSYNC_IN) ##1 COMSYNC_IN [*3] |-> ##[0:1] ser_status[7]
  ) else $error("comm sync rise not captured");

  host_read_a : assert property (
    acc && !HWRITE_IN && map_ok && a_idx == IDX_HOST_EVENT |=> HRDATA_OUT[7:0] == $past(HOST_EVENTS_IN)
  ) else $error("host status read mismatch");

  // An event landing with its own clear must survive
  set_wins_a : assert property (
    wr_dec_clr && wdata[7] && DEC_EVENTS_IN.block_decoded |=> dec_status[7]
  ) else $error("decoder event lost to a same-cycle clear");

  dec_crc_a : assert property (
    DEC_EVENTS_IN.block_check_bad_flag |=> dec_status[2]
  ) else $error("block check event not latched");

  host_zero_a : assert property (
    XFER_EVENTS_IN.host_count_zero |=> xfer_status[7]
  ) else $error("host count zero not latched");

  drive_reload_a : assert property (
    XFER_EVENTS_IN.drive_reload |=> xfer_status[6]
  ) else $error("drive reload not latched");

  copy_done_a : assert property (
    XFER_EVENTS_IN.copy_done |=> xfer_status[4]
  ) else $error("copy done not latched");

  early_sync_a : assert property (
    XFER_EVENTS_IN.subcode_early_sync |=> xfer_status[3]
  ) else $error("early subcode sync not latched");

  dma_set_a : assert property (
    XFER_EVENTS_IN.dma_count_zero && XFER_EVENTS_IN.dma_active |=> xfer_status[2]
  ) else $error("active transfer count zero not latched");

  xfer_clear_a : assert property (
    wr_xfer_clr && wdata[7] && !XFER_EVENTS_IN.host_count_zero |=> !xfer_status[7]
  ) else $error("transfer bit 7 not cleared by write one");

  ser_clear_a : assert property (
    wr_ser_clr && wdata[0] && !SER_EVENTS_IN.rx_parity_bad |=> !ser_status[0]
  ) else $error("serial bit 0 not cleared by write one");

  ser_read_a : assert property (
    acc && !HWRITE_IN && map_ok && a_idx == IDX_SER_EVENT |-> rdata_nxt[7:0] == (ser_status & ser_mask)
  ) else $error("serial read ignores its enables");

  xfer_summary_a : assert property (
    acc && !HWRITE_IN && map_ok && a_idx == IDX_XFER_EVENT |->
      rdata_nxt[XFER_DEC_BIT] == (|(dec_status & dec_mask & DEC_CLR_BITS))
  ) else $error("transfer summary misses decoder event");

  com_fall_a : assert property (
    $fell(COMSYNC_IN) ##1 (!COMSYNC_IN) [*3] |-> ##[0:1] ser_status[5]
  ) else $error("comm sync fall not captured");

  drive_idle_a : assert property (
    !(dec_pend || xfer_pend || ser_pend) |=> DRIVE_REQ_N_OUT
  ) else $error("drive request active with nothing pending");

  bad_addr_a : assert property (
    acc && !HWRITE_IN && !map_ok |=> HRDATA_OUT == RDATA_ZERO
  ) else $error("unmapped read returned data");
endmodule : dui_ctrl
`default_nettype wire

// File: rtl/dui_event_group.sv
`timescale 1ns/10ps
`default_nettype none
module dui_event_group #(
  parameter logic [7:0] CLR_BITS = 8'hFF
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Events and software writes
  input  wire logic [7:0] set_in,
  input  wire logic       clr_wr_in,
  input  wire logic       mask_wr_in,
  input  wire logic [7:0] wdata_in,
  // State
  output logic      [7:0] status_out,
  output logic      [7:0] mask_out,
  output logic      [7:0] shown_out,
  output logic            pending_out
);
  import dui_pkg::*;

  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] status_nxt;
  logic [7:0] clr_bits;

  assign clr_bits   = clr_wr_in ? (wdata_in & CLR_BITS) : 8'h00;
  // Set beats clear so an event in the clearing cycle survives
  assign status_nxt = (status_r & ~clr_bits) | set_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_r <= MASK_RST;
    end else if (mask_wr_in) begin
      mask_r <= wdata_in;
    end
  end

  assign status_out  = status_r;
  assign mask_out    = mask_r;
  assign shown_out   = status_r & mask_r;
  assign pending_out = |(status_r & mask_r & CLR_BITS);
endmodule : dui_event_group
`default_nettype wire

// File: rtl/dui_pin_edge.sv
`timescale 1ns/10ps
`default_nettype none
module dui_pin_edge (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pin and edges
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Pin is asynchronous; meta_r is never looked at, edges come from sync_r and prev_r
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;
endmodule : dui_pin_edge
`default_nettype wire

// File: rtl/dui_pkg.sv
`default_nettype none
package dui_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_SER_EVENT   = 16'hFF78;
  localparam logic [15:0] IDX_SER_MASK    = 16'hFF79;
  localparam logic [15:0] IDX_DEC_EVENT   = 16'hFF7A;
  localparam logic [15:0] IDX_DEC_MASK    = 16'hFF7B;
  localparam logic [15:0] IDX_XFER_EVENT  = 16'hFF7C;
  localparam logic [15:0] IDX_XFER_MASK   = 16'hFF7D;
  localparam logic [15:0] IDX_HOST_EVENT  = 16'hFF92;

  // Address field layout
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_MSB         = 17;
  localparam logic [13:0] ADDR_HI_ZERO    = 14'h0000;
  localparam logic [1:0]  ADDR_LO_ZERO    = 2'h0;

  // Reset values and clearable bit sets
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam logic [7:0]  STATUS_RST      = 8'h00;
  localparam logic [7:0]  DEC_CLR_BITS    = 8'hFE;
  localparam logic [7:0]  XFER_CLR_BITS   = 8'hFC;
  localparam logic [7:0]  SER_CLR_BITS    = 8'hFF;

  // Summary bit positions
  localparam int          DEC_XFER_BIT    = 0;
  localparam int          XFER_DEC_BIT    = 1;
  localparam int          XFER_SER_BIT    = 0;

  // AHB-Lite codes
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;
  localparam logic [31:0] RDATA_ZERO      = 32'h00000000;

  typedef struct packed {
    logic block_decoded;
    logic no_correct_start;
    logic input_flagged;
    logic block_corrected;
    logic bytes_in_error;
    logic block_check_bad_flag;
    logic qchannel_check_bad_flag;
  } dui_dec_ev_t;

  typedef struct packed {
    logic host_count_zero;
    logic drive_reload;
    logic host_reloads_exhausted_flag;
    logic copy_done;
    logic subcode_early_sync;
    logic dma_count_zero;
    logic dma_active;
  } dui_xfer_ev_t;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic rx_overrun;
    logic rx_parity_bad;
  } dui_ser_ev_t;

endpackage : dui_pkg
`default_nettype wire

// File: test/dui_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module dui_cpu_model (
  // Clock and bus answer
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  // Bus request
  output logic             hsel_out,
  output logic [31:0]      haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  import dui_pkg::*;
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h00000000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h00000000;
  end
  // Single word transfer; no wait count assumed, the bench watchdog ends a hang
  task automatic xfer_raw(input logic w, input logic [31:0] addr,
                          input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_out <= 1'b1;
    htrans_out <= HTRANS_NONSEQ;
    haddr_out <= addr;
    hwrite_out <= w;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= {24'h000000, wd};
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
  endtask : xfer_raw

  // Aligned word at a register index
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    xfer_raw(w, {ADDR_HI_ZERO, idx, ADDR_LO_ZERO}, wd, rd);
  endtask : xfer
endmodule : dui_cpu_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dui_pkg::*;
  logic         clk;
  logic         rst;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic [7:0]   host_ev;
  dui_dec_ev_t  dec_ev;
  dui_xfer_ev_t xfer_ev;
  dui_ser_ev_t  ser_ev;
  logic         com_sync;
  logic         sys_sync;
  logic         host_req_n;
  logic         drive_req_n;
  int           fail_count;
  int           checked;
  logic [15:0]  regs [7] = '{IDX_SER_EVENT, IDX_SER_MASK, IDX_DEC_EVENT, IDX_DEC_MASK,
                            IDX_XFER_EVENT, IDX_XFER_MASK, IDX_HOST_EVENT};

  dui_ctrl u_dut (.REF_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HOST_EVENTS_IN(host_ev), .DEC_EVENTS_IN(dec_ev), .XFER_EVENTS_IN(xfer_ev),
    .SER_EVENTS_IN(ser_ev), .COMSYNC_IN(com_sync), .SYSSYNC_IN(sys_sync),
    .HOST_REQ_N_OUT(host_req_n), .DRIVE_REQ_N_OUT(drive_req_n));

  dui_cpu_model u_cpu (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d fails %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    u_cpu.xfer(1'b0, idx, 8'h00, d);
    ck(d, {24'h000000, exp});
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    u_cpu.xfer(1'b1, idx, wd, d);
  endtask : wr

  // One-cycle event pulse, then settle past the two-cycle pin delay
  task automatic pulse(input logic [6:0] d, input logic [6:0] x, input logic [3:0] s);
    @(posedge clk);
    dec_ev <= d;
    xfer_ev <= x;
    ser_ev <= s;
    @(posedge clk);
    dec_ev <= '0;
    xfer_ev <= '0;
    ser_ev <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  task automatic t_reset;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(IDX_DEC_MASK, 8'hFF);
    rd(IDX_DEC_MASK, 8'h00);
    wr(16'hFF7E, 8'hFF);
    rd(16'hFF7E, 8'h00);
    ck(hresp, HRESP_OKAY);
    ck({host_req_n, drive_req_n}, 2'h3);
    $display("reset done");
  endtask : t_reset

  task automatic t_dec;
    for (int b = 1; b < 8; b++) begin
      pulse(7'h01 << (b - 1), 7'h00, 4'h0);
      ck(drive_req_n, 1'b0);
      ck(host_req_n, 1'b1);
      rd(IDX_DEC_EVENT, 8'h01 << b);
      wr(IDX_DEC_EVENT, ~(8'h01 << b));
      rd(IDX_DEC_EVENT, 8'h01 << b);
      wr(IDX_DEC_EVENT, 8'h01 << b);
      rd(IDX_DEC_EVENT, 8'h00);
      ck(drive_req_n, 1'b1);
    end
    $display("dec done");
  endtask : t_dec

  task automatic t_mask;
    wr(IDX_DEC_MASK, 8'h00);
    pulse(7'h40, 7'h00, 4'h0);
    rd(IDX_DEC_EVENT, 8'h00);
    ck(drive_req_n, 1'b1);
    wr(IDX_DEC_MASK, 8'h80);
    rd(IDX_DEC_EVENT, 8'h80);
    ck(drive_req_n, 1'b0);
    wr(IDX_DEC_EVENT, 8'h80);
    $display("mask done");
  endtask : t_mask

  task automatic t_xfer;
    wr(IDX_XFER_MASK, 8'hFC);
    for (int b = 3; b < 8; b++) begin
      pulse(7'h00, 7'h01 << (b - 1), 4'h0);
      rd(IDX_XFER_EVENT, 8'h01 << b);
      ck(drive_req_n, 1'b0);
      wr(IDX_XFER_EVENT, 8'h01 << b);
      rd(IDX_XFER_EVENT, 8'h00);
    end
    pulse(7'h00, 7'h02, 4'h0);
    rd(IDX_XFER_EVENT, 8'h00);
    pulse(7'h00, 7'h03, 4'h0);
    rd(IDX_XFER_EVENT, 8'h04);
    wr(IDX_XFER_EVENT, 8'h04);
    $display("xfer done");
  endtask : t_xfer

  task automatic t_summary;
    wr(IDX_DEC_MASK, 8'h01);
    wr(IDX_XFER_MASK, 8'h80);
    pulse(7'h00, 7'h40, 4'h0);
    rd(IDX_DEC_EVENT, 8'h01);
    wr(IDX_DEC_EVENT, 8'hFF);
    rd(IDX_DEC_EVENT, 8'h01);
    wr(IDX_XFER_EVENT, 8'h80);
    rd(IDX_DEC_EVENT, 8'h00);
    wr(IDX_DEC_MASK, 8'h80);
    pulse(7'h40, 7'h00, 4'h0);
    rd(IDX_XFER_EVENT, 8'h02);
    wr(IDX_DEC_EVENT, 8'h80);
    wr(IDX_SER_MASK, 8'h01);
    pulse(7'h00, 7'h00, 4'h1);
    rd(IDX_XFER_EVENT, 8'h01);
    wr(IDX_SER_EVENT, 8'h01);
    rd(IDX_XFER_EVENT, 8'h00);
    ck(drive_req_n, 1'b1);
    $display("summary done");
  endtask : t_summary

  // Sync pins pass a two-flop synchroniser, so allow a few cycles
  task automatic pin_step(input logic c, input logic s, input logic [7:0] exp);
    @(posedge clk);
    com_sync <= c;
    sys_sync <= s;
    repeat (6) @(posedge clk);
    rd(IDX_SER_EVENT, exp);
  endtask : pin_step

  task automatic t_ser;
    wr(IDX_SER_MASK, 8'hFF);
    for (int b = 0; b < 4; b++) begin
      pulse(7'h00, 7'h00, 4'h1 << b);
      rd(IDX_SER_EVENT, 8'h01 << b);
      wr(IDX_SER_EVENT, 8'h01 << b);
      rd(IDX_SER_EVENT, 8'h00);
    end
    pin_step(1'b1, 1'b0, 8'h80);
    pin_step(1'b1, 1'b1, 8'hC0);
    pin_step(1'b0, 1'b1, 8'hE0);
    pin_step(1'b0, 1'b0, 8'hF0);
    ck(drive_req_n, 1'b0);
    wr(IDX_SER_EVENT, 8'hFF);
    rd(IDX_SER_EVENT, 8'h00);
    $display("ser done");
  endtask : t_ser

  task automatic t_host;
    @(posedge clk);
    host_ev <= 8'h08;
    repeat (3) @(posedge clk);
    #1;
    ck({host_req_n, drive_req_n}, 2'h1);
    rd(IDX_HOST_EVENT, 8'h08);
    @(posedge clk);
    host_ev <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
    ck(host_req_n, 1'b1);
    $display("host done");
  endtask : t_host

  // Off-map and misaligned words are ignored; an event beats its own clear
  task automatic t_map;
    logic [31:0] d;
    wr(IDX_DEC_MASK, 8'hFF);
    pulse(7'h40, 7'h00, 4'h0);
    u_cpu.xfer_raw(1'b1, {ADDR_HI_ZERO, IDX_DEC_EVENT, 2'h1}, 8'hFF, d);
    u_cpu.xfer_raw(1'b1, {14'h0001, IDX_DEC_EVENT, ADDR_LO_ZERO}, 8'hFF, d);
    rd(IDX_DEC_EVENT, 8'h80);
    u_cpu.xfer_raw(1'b0, {ADDR_HI_ZERO, IDX_DEC_EVENT, 2'h2}, 8'h00, d);
    ck(d, RDATA_ZERO);
    fork
      wr(IDX_DEC_EVENT, 8'h80);
      begin
        repeat (2) @(posedge clk);
        dec_ev <= 7'h40;
        @(posedge clk);
        dec_ev <= '0;
      end
    join
    rd(IDX_DEC_EVENT, 8'h80);
    wr(IDX_DEC_EVENT, 8'h80);
    rd(IDX_DEC_EVENT, 8'h00);
    $display("map done");
  endtask : t_map

  // Reset in mid-run drops latched events and the request pin
  task automatic t_rerun;
    wr(IDX_DEC_MASK, 8'hFF);
    pulse(7'h40, 7'h00, 4'h0);
    ck(drive_req_n, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    ck({host_req_n, drive_req_n}, 2'h3);
    wr(IDX_DEC_MASK, 8'hFF);
    rd(IDX_DEC_EVENT, 8'h00);
    $display("rerun done");
  endtask : t_rerun

  initial begin
    rst = 1'b1;
    host_ev = 8'h00;
    dec_ev = '0;
    xfer_ev = '0;
    ser_ev = '0;
    com_sync = 1'b0;
    sys_sync = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_dec;
    t_mask;
    t_xfer;
    t_summary;
    t_ser;
    t_map;
    t_rerun;
    t_host;
    wrap_up;
  end

  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200000;
    fail_count++;
    $display("FAIL at %0t: watchdog", $time);
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
